// ===== fsbp_consts.vh
/*
 constants for the host-side controller of a shared flash/sram bus.
 assumes a 200 MHz system clock; counts are cycles of that clock.
*/
`ifndef FSBP_CONSTS_VH
`define FSBP_CONSTS_VH
`define FSBP_CLK_MHZ 200
`define FSBP_ACCESS_NS 70
`define FSBP_ACCESS_CYC ((`FSBP_ACCESS_NS * `FSBP_CLK_MHZ + 999) / 1000)
`define FSBP_RESET_NS 100
`define FSBP_RESET_CYC ((`FSBP_RESET_NS * `FSBP_CLK_MHZ + 999) / 1000)
`define FSBP_ADDR_W 21
`define FSBP_DATA_W 16
`define FSBP_OP_READ 2'h0
`define FSBP_OP_WRITE 2'h1
`define FSBP_OP_PROG 2'h2
`define FSBP_OP_ERASE 2'h3
`define FSBP_CMD_PROG 16'h0040
`define FSBP_CMD_ERASE 16'h0020
`define FSBP_CMD_CONFIRM 16'h00D0
`endif

// ===== fsbp_phase_timer.v
/*
 phase timer: counts a fixed number of clock cycles after a start pulse.
 assumes start is a one-cycle pulse in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fsbp_phase_timer #(
    parameter CW = 8
) (
    input wire clk,
    input wire arst_n,
    input wire start,
    input wire [CW-1:0] length,
    output reg done
);
    reg [CW-1:0] count;
    reg busy;
    // load on start, raise done for one cycle when the count runs out
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= {CW{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= length;
                busy <= 1'b1;
            end else if (busy) begin
                if (count <= {{(CW-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== fsbp_host.v
/*
 host controller driving a stacked flash + sram package over its pins.
 assumes the package pins are joined by the testbench; data pins are split
 into input, output and output enable; pin inputs synchronous to CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsbp_consts.vh"
module fsbp_host #(
    parameter AW = `FSBP_ADDR_W,
    parameter DW = `FSBP_DATA_W
) (
    input wire CLOCK,
    input wire ARST_N,
    input wire REQ_VALID,
    input wire REQ_SRAM,
    input wire [1:0] REQ_OP,
    input wire [AW-1:0] REQ_ADDR,
    input wire [DW-1:0] REQ_WDATA,
    input wire [1:0] REQ_LANES,
    output reg REQ_READY,
    output reg RSP_VALID,
    output reg [DW-1:0] RSP_RDATA,
    output reg [AW-1:0] ADDR,
    input wire [DW-1:0] DQ_IN,
    output reg [DW-1:0] DQ_OUT,
    output reg DQ_OE,
    output reg FLASH_SELECT_N,
    output reg FLASH_OUTPUT_N,
    output reg FLASH_WRITE_N,
    output reg FLASH_RESET_N,
    output reg SRAM_SELECT_LOW_N,
    output reg SRAM_SELECT_HIGH,
    output reg SRAM_OUTPUT_N,
    output reg SRAM_WRITE_N,
    output reg SRAM_UPPER_LANE_N,
    output reg SRAM_LOWER_LANE_N
);
    localparam ST_RESET = 3'h0;
    localparam ST_IDLE = 3'h1;
    localparam ST_READ = 3'h2;
    localparam ST_WRITE = 3'h3;
    localparam ST_GAP = 3'h4;
    localparam ST_DONE = 3'h5;
    // timer loads cut to the timer's 8-bit width on purpose
    localparam integer RESET_CYC = `FSBP_RESET_CYC;
    localparam integer ACCESS_CYC = `FSBP_ACCESS_CYC;
    localparam [7:0] RESET_LEN = RESET_CYC[7:0];
    localparam [7:0] ACCESS_LEN = ACCESS_CYC[7:0];

    reg [2:0] state;
    reg [2:0] next_state;
    reg second; // second bus write of a command sequence pending
    reg [1:0] op;
    reg [AW-1:0] addr_hold;
    reg [DW-1:0] data_hold;
    reg timer_start;
    reg [7:0] timer_len;
    wire timer_done;

    // cycle timer that paces each strobe phase
    fsbp_phase_timer #(.CW(8)) u_timer (
        .clk(CLOCK),
        .arst_n(ARST_N),
        .start(timer_start),
        .length(timer_len),
        .done(timer_done)
    );

    // next state from the current phase and the timer
    always @* begin
        next_state = state;
        case (state)
            ST_RESET: if (timer_done) next_state = ST_IDLE;
            ST_IDLE: begin
                if (REQ_VALID && REQ_READY) begin
                    if (!REQ_SRAM && REQ_OP == `FSBP_OP_READ)
                        next_state = ST_READ;
                    else if (REQ_SRAM && REQ_OP == `FSBP_OP_READ)
                        next_state = ST_READ;
                    else
                        next_state = ST_WRITE;
                end
            end
            ST_READ: if (timer_done) next_state = ST_DONE;
            ST_WRITE: if (timer_done) next_state = ST_GAP;
            ST_GAP: if (timer_done) next_state = second ? ST_WRITE : ST_DONE;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    // pin sequencing: only one die selected at a time, data driven on writes
    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= ST_RESET;
            second <= 1'b0;
            op <= 2'h0;
            addr_hold <= {AW{1'b0}};
            data_hold <= {DW{1'b0}};
            timer_start <= 1'b1;
            timer_len <= RESET_LEN;
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= {DW{1'b0}};
            ADDR <= {AW{1'b0}};
            DQ_OUT <= {DW{1'b0}};
            DQ_OE <= 1'b0;
            FLASH_SELECT_N <= 1'b1;
            FLASH_OUTPUT_N <= 1'b1;
            FLASH_WRITE_N <= 1'b1;
            FLASH_RESET_N <= 1'b0;
            SRAM_SELECT_LOW_N <= 1'b1;
            SRAM_SELECT_HIGH <= 1'b0;
            SRAM_OUTPUT_N <= 1'b1;
            SRAM_WRITE_N <= 1'b1;
            SRAM_UPPER_LANE_N <= 1'b1;
            SRAM_LOWER_LANE_N <= 1'b1;
        end else begin
            state <= next_state;
            timer_start <= 1'b0;
            RSP_VALID <= 1'b0;
            case (state)
                ST_RESET: begin
                    if (timer_done) begin
                        FLASH_RESET_N <= 1'b1;
                        REQ_READY <= 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (REQ_VALID && REQ_READY) begin
                        REQ_READY <= 1'b0;
                        op <= REQ_OP;
                        addr_hold <= REQ_ADDR;
                        data_hold <= REQ_WDATA;
                        ADDR <= REQ_ADDR;
                        timer_start <= 1'b1;
                        timer_len <= ACCESS_LEN;
                        // program/erase need a setup write, then the word or the confirm write
                        second <= !REQ_SRAM && REQ_OP[1];
                        if (REQ_SRAM) begin
                            SRAM_SELECT_LOW_N <= 1'b0;
                            SRAM_SELECT_HIGH <= 1'b1;
                            SRAM_UPPER_LANE_N <= !REQ_LANES[1];
                            SRAM_LOWER_LANE_N <= !REQ_LANES[0];
                            if (REQ_OP == `FSBP_OP_READ) begin
                                SRAM_OUTPUT_N <= 1'b0;
                            end else begin
                                SRAM_WRITE_N <= 1'b0;
                                DQ_OUT <= REQ_WDATA;
                                DQ_OE <= 1'b1;
                            end
                        end else begin
                            FLASH_SELECT_N <= 1'b0;
                            if (REQ_OP == `FSBP_OP_READ) begin
                                FLASH_OUTPUT_N <= 1'b0;
                            end else begin
                                FLASH_WRITE_N <= 1'b0;
                                DQ_OE <= 1'b1;
                                case (REQ_OP)
                                    `FSBP_OP_PROG: DQ_OUT <= `FSBP_CMD_PROG;
                                    `FSBP_OP_ERASE: DQ_OUT <= `FSBP_CMD_ERASE;
                                    default: DQ_OUT <= REQ_WDATA;
                                endcase
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (timer_done) begin
                        RSP_RDATA <= DQ_IN;
                        // deselect lets the flash drop to power saving
                        FLASH_OUTPUT_N <= 1'b1;
                        FLASH_SELECT_N <= 1'b1;
                        SRAM_OUTPUT_N <= 1'b1;
                        SRAM_SELECT_LOW_N <= 1'b1;
                        SRAM_SELECT_HIGH <= 1'b0;
                        SRAM_UPPER_LANE_N <= 1'b1;
                        SRAM_LOWER_LANE_N <= 1'b1;
                    end
                end
                ST_WRITE: begin
                    if (timer_done) begin
                        // rising write edge latches address and data;
                        // selects and lanes stay on across this edge
                        FLASH_WRITE_N <= 1'b1;
                        SRAM_WRITE_N <= 1'b1;
                        timer_start <= 1'b1;
                        timer_len <= ACCESS_LEN;
                    end
                end
                ST_GAP: begin
                    // deselect one cycle after the write edge, so a select
                    // never rises together with its strobe
                    FLASH_SELECT_N <= 1'b1;
                    SRAM_SELECT_LOW_N <= 1'b1;
                    SRAM_SELECT_HIGH <= 1'b0;
                    SRAM_UPPER_LANE_N <= 1'b1;
                    SRAM_LOWER_LANE_N <= 1'b1;
                    if (timer_done) begin
                        DQ_OE <= second;
                        if (second) begin
                            second <= 1'b0;
                            FLASH_SELECT_N <= 1'b0;
                            FLASH_WRITE_N <= 1'b0;
                            timer_start <= 1'b1;
                            timer_len <= ACCESS_LEN;
                            ADDR <= addr_hold;
                            // program: the word; erase: the confirm code
                            if (op == `FSBP_OP_PROG)
                                DQ_OUT <= data_hold;
                            else
                                DQ_OUT <= `FSBP_CMD_CONFIRM;
                        end
                    end
                end
                ST_DONE: begin
                    RSP_VALID <= 1'b1;
                    REQ_READY <= 1'b1;
                    DQ_OE <= 1'b0;
                end
                default: begin
                    REQ_READY <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== fsbp_host_assertions.sv
/*
 pin-level checker for the shared flash/sram host controller.
 assumes binding to fsbp_host; one clock, asynchronous low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fsbp_host_assertions (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire logic [20:0] ADDR,
    input wire logic [15:0] DQ_OUT,
    input wire logic DQ_OE,
    input wire logic FLASH_SELECT_N,
    input wire logic FLASH_OUTPUT_N,
    input wire logic FLASH_WRITE_N,
    input wire logic FLASH_RESET_N,
    input wire logic SRAM_SELECT_LOW_N,
    input wire logic SRAM_SELECT_HIGH,
    input wire logic SRAM_OUTPUT_N,
    input wire logic SRAM_WRITE_N
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    // pin relations checked every clock
    a_one_die_only: assert property (!FLASH_SELECT_N |-> SRAM_SELECT_LOW_N)
        else $error("both dies selected");
    a_no_bus_fight: assert property (DQ_OE |-> FLASH_OUTPUT_N && SRAM_OUTPUT_N)
        else $error("host drives while a die outputs");
    a_flash_cmd_sel: assert property (!FLASH_WRITE_N |-> !FLASH_SELECT_N && DQ_OE)
        else $error("flash write without select");
    a_sram_wr_sel: assert property (!SRAM_WRITE_N |->
        !SRAM_SELECT_LOW_N && SRAM_SELECT_HIGH && DQ_OE)
        else $error("sram write without selection");
    a_wr_data_held: assert property (!FLASH_WRITE_N && $past(!FLASH_WRITE_N)
        |-> $stable(DQ_OUT) && $stable(ADDR))
        else $error("write data moved during strobe");
    a_wr_pulse_len: assert property ($fell(FLASH_WRITE_N) |-> !FLASH_WRITE_N [*8])
        else $error("flash write strobe too short");
    a_wr_sel_held: assert property ($rose(FLASH_WRITE_N)
        |-> !FLASH_SELECT_N)
        else $error("flash deselected at write edge");
    a_sram_edge_sel: assert property ($rose(SRAM_WRITE_N)
        |-> !SRAM_SELECT_LOW_N && SRAM_SELECT_HIGH)
        else $error("sram deselected at write edge");
    a_reset_hold: assert property ($rose(ARST_N) |-> !FLASH_RESET_N [*8])
        else $error("flash reset released early");
    a_rsp_one_shot: assert property (RSP_VALID |=> !RSP_VALID)
        else $error("response longer than one cycle");
    a_idle_standby: assert property (REQ_READY |->
        FLASH_SELECT_N && SRAM_SELECT_LOW_N)
        else $error("die selected while idle");
    a_take_busy: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
        else $error("ready kept after take");
endmodule
bind fsbp_host fsbp_host_assertions u_chk (.*);
`default_nettype wire

// ===== fsbp_device_model.sv
/*
 behavioural flash + sram package sharing one address and data bus.
 assumes pins come from the host controller; it has no clock of its own.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsbp_consts.vh"
module fsbp_device_model (
    input wire logic [20:0] ADDR,
    input wire logic [15:0] DQ_OUT,
    input wire logic DQ_OE,
    input wire logic FLASH_SELECT_N,
    input wire logic FLASH_OUTPUT_N,
    input wire logic FLASH_WRITE_N,
    input wire logic FLASH_RESET_N,
    input wire logic SRAM_SELECT_LOW_N,
    input wire logic SRAM_SELECT_HIGH,
    input wire logic SRAM_OUTPUT_N,
    input wire logic SRAM_WRITE_N,
    input wire logic SRAM_UPPER_LANE_N,
    input wire logic SRAM_LOWER_LANE_N,
    output var logic [15:0] DQ_IN
);
    logic [15:0] fm [int];
    logic [15:0] sm [int];
    logic [15:0] flt = 16'hA5C3;
    logic [1:0] st = 2'h0;
    wire fl_on = FLASH_RESET_N === 1'b1 && FLASH_SELECT_N === 1'b0;
    wire sr_on = SRAM_SELECT_LOW_N === 1'b0 && SRAM_SELECT_HIGH === 1'b1;
    // bottom boot: the lowest 32-Kword span holds eight 4-Kword blocks
    function automatic logic same_block(input int k, input logic [20:0] a);
        if (a[20:15] == 6'h00) return k[20:12] == {6'h00, a[14:12]};
        return k[20:15] == a[20:15];
    endfunction
    // a released bus shows a pattern that keeps changing
    always #2.5 flt = ~flt;
    // read path: drive only the addressed die with outputs enabled
    always @* begin
        DQ_IN = flt;
        if (fl_on && FLASH_OUTPUT_N === 1'b0) begin
            DQ_IN = fm.exists(ADDR) ? fm[ADDR] : 16'hFFFF;
        end else if (sr_on && SRAM_OUTPUT_N === 1'b0) begin
            DQ_IN = sm[ADDR];
            if (SRAM_UPPER_LANE_N) DQ_IN[15:8] = flt[15:8];
            if (SRAM_LOWER_LANE_N) DQ_IN[7:0] = flt[7:0];
        end
    end
    // reset low clears the command state back to array read
    always @(negedge FLASH_RESET_N) st = 2'h0;
    // command interface takes a word on the rising write edge
    always @(posedge FLASH_WRITE_N) if (fl_on && DQ_OE) begin
        if (st == 2'h1) begin
            fm[ADDR] = DQ_OUT;
            st = 2'h0;
        end else begin
            if (st == 2'h2 && DQ_OUT == `FSBP_CMD_CONFIRM)
                foreach (fm[k]) if (same_block(k, ADDR)) fm[k] = 16'hFFFF;
            st = DQ_OUT == `FSBP_CMD_PROG ? 2'h1 :
                 DQ_OUT == `FSBP_CMD_ERASE ? 2'h2 : 2'h0;
        end
    end
    // sram latches enabled byte lanes on the rising write edge
    always @(posedge SRAM_WRITE_N) if (sr_on) begin
        if (!sm.exists(ADDR)) sm[ADDR] = 16'h0000;
        if (!SRAM_UPPER_LANE_N) sm[ADDR][15:8] = DQ_OUT[15:8];
        if (!SRAM_LOWER_LANE_N) sm[ADDR][7:0] = DQ_OUT[7:0];
    end
endmodule
`default_nettype wire

// ===== tb_flash_sram_shared_bus_port.sv
/*
 self-checking bench for the shared flash/sram host controller.
 assumes fsbp_device_model on the pins; expected reads kept in a queue.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_flash_sram_shared_bus_port;
    logic CLOCK = 0, ARST_N = 0, REQ_VALID = 0, REQ_SRAM = 0;
    logic [1:0] REQ_OP = 0, REQ_LANES = 0;
    logic [20:0] REQ_ADDR = 0, ADDR;
    logic [15:0] REQ_WDATA = 0, RSP_RDATA, DQ_IN, DQ_OUT, d, e, f, w;
    logic REQ_READY, RSP_VALID, DQ_OE, FLASH_SELECT_N, FLASH_OUTPUT_N;
    logic FLASH_WRITE_N, FLASH_RESET_N, SRAM_SELECT_LOW_N, SRAM_SELECT_HIGH;
    logic SRAM_OUTPUT_N, SRAM_WRITE_N, SRAM_UPPER_LANE_N, SRAM_LOWER_LANE_N;
    logic [16:0] q[$];
    logic [16:0] note;
    int n_fail = 0, compares = 0, seed = 32'he2df8a73;
    fsbp_host u_dut (.*);
    fsbp_device_model u_mem (.*);
    always #2.5 CLOCK = ~CLOCK;
    // print the counts and the verdict, then stop
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one request; note bit 16 marks a read whose data is expected
    task automatic req(input logic s, input logic [1:0] op,
            input logic [20:0] a, input logic [15:0] wd,
            input logic [1:0] ln, input logic [16:0] nt);
        q.push_back(nt);
        {REQ_SRAM, REQ_OP, REQ_ADDR, REQ_WDATA, REQ_LANES} = {s, op, a, wd, ln};
        REQ_VALID = 1;
        while (REQ_READY !== 1'b1) @(posedge CLOCK) #1;
        @(posedge CLOCK) #1;
        REQ_VALID = 0;
        while (q.size() > 0) @(posedge CLOCK) #1;
    endtask
    // take the oldest note whenever a response shows up
    always @(negedge CLOCK) if (RSP_VALID === 1'b1) begin
        note = q.size() > 0 ? q.pop_front() : 17'h1FFFF;
        if (note[16]) `CHK("read data", note[15:0], RSP_RDATA)
    end
    // main sequence
    initial begin
        repeat (20) @(posedge CLOCK);
        #1 ARST_N = 1;
        d = $random(seed);
        e = $random(seed);
        f = $random(seed);
        w = $random(seed);
        req(1, 1, 21'h00123, d, 2'h3, 0);
        req(1, 0, 21'h00123, 0, 2'h3, {1'b1, d});
        req(1, 1, 21'h00123, e, 2'h2, 0);
        req(1, 0, 21'h00123, 0, 2'h3, {1'b1, e[15:8], d[7:0]});
        req(1, 1, 21'h00123, f, 2'h1, 0);
        req(1, 0, 21'h00123, 0, 2'h3, {1'b1, e[15:8], f[7:0]});
        $display("sram lane test done");
        req(0, 2, 21'h08010, w, 0, 0);
        req(0, 2, 21'h10020, ~w, 0, 0);
        req(0, 0, 21'h08010, 0, 0, {1'b1, w});
        req(0, 3, 21'h08000, 0, 0, 0);
        req(0, 0, 21'h08010, 0, 0, {1'b1, 16'hFFFF});
        req(0, 1, 21'h00000, 16'h00FF, 0, 0);
        req(0, 0, 21'h10020, 0, 0, {1'b1, ~w});
        req(0, 2, 21'h00010, d, 0, 0);
        req(0, 2, 21'h01010, e, 0, 0);
        req(0, 3, 21'h00000, 0, 0, 0);
        req(0, 0, 21'h00010, 0, 0, {1'b1, 16'hFFFF});
        req(0, 0, 21'h01010, 0, 0, {1'b1, e});
        `CHK("standby", 2'h3, {FLASH_SELECT_N, SRAM_SELECT_LOW_N})
        $display("flash test done");
        ARST_N = 0;
        @(posedge CLOCK) #1 ARST_N = 1;
        `CHK("flash reset pin", 1'b0, FLASH_RESET_N)
        req(0, 0, 21'h10020, 0, 0, {1'b1, ~w});
        $display("reset test done");
        conclude;
    end
    // cut a hang short well after the expected run length
    initial begin
        #60000;
        n_fail++;
        $display("[FAIL] watchdog exp done got hang");
        conclude;
    end
endmodule
`default_nettype wire
